/* File: design/ivp_pkg.sv */
// package of constants for the interrupt priority and vector logic
// assumes a single clock domain and an ahb-lite register slave
//
// Notes on behaviour
// RULE1 - six groups pair sources for priority; group five holds ext6 alone
// RULE2 - group level is high bit, low bit
// RULE3 - equal levels resolved by fixed polling order
// RULE4 - disabled sources never raise a request
// RULE5 - flags set by events, cleared on acceptance
// RULE6 - each source maps to its fixed vector
// RULE7 - external zero wakes a stopped cpu
// RULE8 - priority in bits 5..0, watchdog bit inert
// RULE9 - external zero/one select edge or level
// RULE10 - ext4..6 rising edge, sources clear on read
// RULE11 - only strictly higher level preempts a handler
// RULE12 - serial request from receive or transmit flag
package ivp_pkg;

   localparam int NSRC = 11;

   // source indices in polling order
   localparam logic [3:0] SRC_EXT0 = 4'h0;
   localparam logic [3:0] SRC_SER1 = 4'h1;
   localparam logic [3:0] SRC_TMR0 = 4'h2;
   localparam logic [3:0] SRC_EXT2 = 4'h3;
   localparam logic [3:0] SRC_EXT1 = 4'h4;
   localparam logic [3:0] SRC_EXT3 = 4'h5;
   localparam logic [3:0] SRC_TMR1 = 4'h6;
   localparam logic [3:0] SRC_SER0 = 4'h7;
   localparam logic [3:0] SRC_EXT4 = 4'h8;
   localparam logic [3:0] SRC_EXT5 = 4'h9;
   localparam logic [3:0] SRC_EXT6 = 4'ha;

   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_PRIO_LO = 10'h0a9;
   localparam logic [9:0] IDX_PRIO_HI = 10'h0b9;
   localparam logic [9:0] IDX_ENABLE  = 10'h0c0;
   localparam logic [9:0] IDX_TYPE    = 10'h0c1;
   localparam logic [9:0] IDX_FLAGS   = 10'h0c2;
   localparam logic [9:0] IDX_PERIPH  = 10'h0c3;
   localparam logic [9:0] IDX_STAT    = 10'h0c4;
   localparam logic [9:0] IDX_MASK    = 10'h0c5;
   localparam logic [9:0] IDX_STATE   = 10'h0c6;

   // reset values and fields
   localparam logic [7:0]  PRIO_RST    = 8'h00;
   localparam logic [10:0] ENABLE_RST  = 11'h000;
   localparam logic [3:0]  TYPE_RST    = 4'h0;
   localparam logic [10:0] MASK_RST    = 11'h000;
   localparam int          PRIO_GRP_W  = 6;
   localparam int          WDT_BIT     = 6;
   localparam int          TYPE_EXT0   = 0;
   localparam int          TYPE_EXT1   = 1;
   localparam int          TYPE_EXT2_R = 2;
   localparam int          TYPE_EXT3_R = 3;
   localparam logic [15:0] VEC_RESET   = 16'h0000;

   function automatic logic [2:0] grp_of(input logic [3:0] s);
      unique case (s)
         SRC_EXT0, SRC_SER1: grp_of = 3'h0;
         SRC_TMR0, SRC_EXT2: grp_of = 3'h1;
         SRC_EXT1, SRC_EXT3: grp_of = 3'h2;
         SRC_TMR1, SRC_EXT4: grp_of = 3'h3;
         SRC_SER0, SRC_EXT5: grp_of = 3'h4;
         default:            grp_of = 3'h5;
      endcase
   endfunction : grp_of

   function automatic logic [15:0] vec_of(input logic [3:0] s);
      unique case (s)
         SRC_EXT0: vec_of = 16'h0003;
         SRC_TMR0: vec_of = 16'h000b;
         SRC_EXT1: vec_of = 16'h0013;
         SRC_TMR1: vec_of = 16'h001b;
         SRC_SER0: vec_of = 16'h0023;
         SRC_SER1: vec_of = 16'h0083;
         SRC_EXT2: vec_of = 16'h004b;
         SRC_EXT3: vec_of = 16'h0053;
         SRC_EXT4: vec_of = 16'h005b;
         SRC_EXT5: vec_of = 16'h0063;
         SRC_EXT6: vec_of = 16'h006b;
         default:  vec_of = VEC_RESET;
      endcase
   endfunction : vec_of

endpackage : ivp_pkg

/* File: design/ivp_ctrl.sv */
// interrupt priority, polling and vector logic with ahb-lite registers
// assumes pins and events synchronous to hclk; cpu pulses int_ack and
// int_ret for one cycle each
`timescale 1ns/1ns
module ivp_ctrl
   import ivp_pkg::*;
#(
   parameter int PW = 4
) (
   input  wire logic          hclk,         // cpu clock
   input  wire logic          hresetn,      // async reset, active low
   input  wire logic          hsel,         // slave select
   input  wire logic [31:0]   haddr,        // byte address
   input  wire logic [1:0]    htrans,       // transfer type
   input  wire logic          hwrite,       // write when high
   input  wire logic [2:0]    hsize,        // word only
   input  wire logic [31:0]   hwdata,       // write data
   input  wire logic          hready,       // bus ready
   output logic [31:0]        hrdata,       // read data
   output logic               hreadyout,    // slave ready
   output logic               hresp,        // always okay
   input  wire logic          ext0_n,       // wake capable external input
   input  wire logic          ext1_n,       // external one input
   input  wire logic          ext2_pin,     // external two input
   input  wire logic          ext3_pin,     // external three input
   input  wire logic [PW-1:0] ext4_src,     // ext4 peripheral event pulses
   input  wire logic [PW-1:0] ext5_src,     // ext5 peripheral event pulses
   input  wire logic [PW-1:0] ext6_src,     // ext6 peripheral event pulses
   input  wire logic          tmr0_ovf,     // timer zero overflow pulse
   input  wire logic          tmr1_ovf,     // timer one overflow pulse
   input  wire logic          ser0_rx,      // serial zero receive flag
   input  wire logic          ser0_tx,      // serial zero transmit flag
   input  wire logic          ser1_rx,      // serial one receive flag
   input  wire logic          ser1_tx,      // serial one transmit flag
   input  wire logic          cpu_stopped,  // cpu in stop state
   input  wire logic          int_ack,      // cpu accepts request
   input  wire logic          int_ret,      // handler returned
   output logic               int_req,      // request to cpu
   output logic [15:0]        int_vector,   // vector of request
   output logic [1:0]         int_level,    // level of request
   output logic               wake_req,     // wake from stop
   output logic               irq           // status interrupt line
);

   // ==========================================================
   // registers
   logic [7:0]      prio_lo_r, prio_hi_r;
   logic [10:0]     en_r, mask_r, stat_r, flag_r;
   logic [3:0]      type_r, is_r;
   logic [3*PW-1:0] periph_r;
   logic [2:0]      por_prev_r;
   logic            ext0_prev_r, ext1_prev_r, ext2_prev_r, ext3_prev_r;
   logic            wr_pend_r, rd_pend_r;
   logic [9:0]      idx_r;
   logic [31:0]     hrdata_r;
   logic            int_req_r;
   logic [15:0]     vec_r;
   logic [3:0]      win_idx_r;
   logic [1:0]      win_lvl_r;

   // ==========================================================
   // bus decode
   wire        addr_ok = hsel & htrans[1] & hready;
   wire        wr_fire = wr_pend_r;
   wire        rd_fire = rd_pend_r;
   wire [31:0] w1c     = (wr_fire && idx_r == IDX_STAT) ? hwdata : 32'h0;
   wire        rd_per  = rd_fire && idx_r == IDX_PERIPH;

   assign hreadyout = ~rd_pend_r;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         idx_r     <= 10'h000;
      end else begin
         wr_pend_r <= addr_ok & hwrite;
         rd_pend_r <= addr_ok & ~hwrite;
         if (addr_ok) idx_r <= haddr[11:2];
      end
   end

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      unique case (idx_r)
         IDX_PRIO_LO: rd_mux[7:0]        = prio_lo_r;
         IDX_PRIO_HI: rd_mux[7:0]        = prio_hi_r;
         IDX_ENABLE:  rd_mux[10:0]       = en_r;
         IDX_TYPE:    rd_mux[3:0]        = type_r;
         IDX_FLAGS:   rd_mux[10:0]       = flag_r;
         IDX_PERIPH:  rd_mux[3*PW-1:0]   = periph_r;
         IDX_STAT:    rd_mux[10:0]       = stat_r;
         IDX_MASK:    rd_mux[10:0]       = mask_r;
         IDX_STATE:   rd_mux[21:0]       = {int_req_r, win_lvl_r, win_idx_r, vec_r[10:0], is_r};
         default:     rd_mux             = 32'h0;
      endcase
   end

   // ==========================================================
   // software registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prio_lo_r <= PRIO_RST;
         prio_hi_r <= PRIO_RST;
         en_r      <= ENABLE_RST;
         type_r    <= TYPE_RST;
         mask_r    <= MASK_RST;
         hrdata_r  <= 32'h0;
      end else begin
         if (rd_fire) hrdata_r <= rd_mux;
         if (wr_fire) begin
            unique case (idx_r)
               IDX_PRIO_LO: prio_lo_r <= {1'b0, hwdata[6:0]};
               IDX_PRIO_HI: prio_hi_r <= {2'b00, hwdata[5:0]};
               IDX_ENABLE:  en_r      <= hwdata[10:0];
               IDX_TYPE:    type_r    <= hwdata[3:0];
               IDX_MASK:    mask_r    <= hwdata[10:0];
               default:     ;
            endcase
         end
      end
   end

   // ==========================================================
   // source events
   logic [2:0]  por;
   logic [10:0] set_v;
   always_comb begin
      por[0] = |periph_r[0 +: PW];
      por[1] = |periph_r[PW +: PW];
      por[2] = |periph_r[2*PW +: PW];
      set_v = '0;
      set_v[SRC_EXT0] = type_r[TYPE_EXT0] ? (ext0_prev_r & ~ext0_n) : ~ext0_n; // RULE9
      set_v[SRC_EXT1] = type_r[TYPE_EXT1] ? (ext1_prev_r & ~ext1_n) : ~ext1_n; // RULE9
      set_v[SRC_EXT2] = type_r[TYPE_EXT2_R] ? (~ext2_prev_r & ext2_pin)
                                            : (ext2_prev_r & ~ext2_pin);
      set_v[SRC_EXT3] = type_r[TYPE_EXT3_R] ? (~ext3_prev_r & ext3_pin)
                                            : (ext3_prev_r & ~ext3_pin);
      set_v[SRC_EXT4] = por[0] & ~por_prev_r[0];  // RULE10
      set_v[SRC_EXT5] = por[1] & ~por_prev_r[1];  // RULE10
      set_v[SRC_EXT6] = por[2] & ~por_prev_r[2];  // RULE10
      set_v[SRC_TMR0] = tmr0_ovf;
      set_v[SRC_TMR1] = tmr1_ovf;
      set_v[SRC_SER0] = ser0_rx | ser0_tx;        // RULE12
      set_v[SRC_SER1] = ser1_rx | ser1_tx;        // RULE12
   end

   wire [10:0] ack_clr = (int_ack & int_req_r) ? (11'h001 << win_idx_r) : 11'h000;
   wire [10:0] new_ev  = set_v & ~flag_r;
   wire [3*PW-1:0] per_in = {ext6_src, ext5_src, ext4_src};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_r      <= '0;
         stat_r      <= '0;
         periph_r    <= '0;
         por_prev_r  <= '0;
         ext0_prev_r <= 1'b1;
         ext1_prev_r <= 1'b1;
         ext2_prev_r <= 1'b0;
         ext3_prev_r <= 1'b0;
      end else begin
         flag_r      <= (flag_r & ~ack_clr) | set_v;           // RULE5
         stat_r      <= (stat_r & ~w1c[10:0]) | new_ev;
         periph_r    <= (rd_per ? '0 : periph_r) | per_in;     // RULE10
         por_prev_r  <= por;
         ext0_prev_r <= ext0_n;
         ext1_prev_r <= ext1_n;
         ext2_prev_r <= ext2_pin;
         ext3_prev_r <= ext3_pin;
      end
   end

   assign irq = |(stat_r & mask_r);

   // ==========================================================
   // arbitration
   wire [10:0] pend = flag_r & en_r;                           // RULE4
   logic [3:0] win_idx;
   logic [1:0] win_lvl, lvl, cur_lvl;
   logic       win_any;
   logic [2:0] g;
   always_comb begin
      win_idx = 4'h0;
      win_lvl = 2'b00;
      win_any = 1'b0;
      lvl     = 2'b00;
      g       = 3'h0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         g   = grp_of(4'(i));                                   // RULE1
         lvl = {prio_hi_r[g], prio_lo_r[g]};                    // RULE2 RULE8
         if (pend[i] && (!win_any || lvl >= win_lvl)) begin     // RULE3
            win_idx = 4'(i);
            win_lvl = lvl;
            win_any = 1'b1;
         end
      end
      cur_lvl = is_r[3] ? 2'd3 : is_r[2] ? 2'd2 : is_r[1] ? 2'd1 : 2'd0;
   end

   wire preempt = (is_r == 4'h0) || (win_lvl > cur_lvl);       // RULE11
   wire [3:0] is_top = is_r[3] ? 4'h8 : is_r[2] ? 4'h4 : is_r[1] ? 4'h2 : is_r[0] ? 4'h1 : 4'h0;
   // a return and a preempting accept may share a cycle; keep both
   wire [3:0] is_set = (int_ack && int_req_r) ? (4'h1 << win_lvl_r) : 4'h0;
   wire [3:0] is_clr = int_ret ? is_top : 4'h0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_req_r <= 1'b0;
         vec_r     <= VEC_RESET;
         win_idx_r <= 4'h0;
         win_lvl_r <= 2'b00;
         is_r      <= 4'h0;
      end else begin
         int_req_r <= win_any & preempt & ~int_ack & ~int_ret;
         vec_r     <= vec_of(win_idx);                          // RULE6
         win_idx_r <= win_idx;
         win_lvl_r <= win_lvl;
         is_r      <= (is_r & ~is_clr) | is_set;               // RULE11
      end
   end

   assign int_req    = int_req_r;
   assign int_vector = vec_r;
   assign int_level  = win_lvl_r;
   // works with hclk halted: no flop, the pin gated by cpu_stopped and the external zero enable
   assign wake_req   = cpu_stopped & en_r[SRC_EXT0] & ~ext0_n;  // RULE7

   // ==========================================================
   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_ack_clears_flag: assert property ( // RULE5
      (int_ack && int_req_r && win_idx_r == SRC_TMR0 && !tmr0_ovf)
      |=> !flag_r[SRC_TMR0])
      else $error("accepted timer zero flag not cleared");

   chk_req_needs_enable: assert property ( // RULE4
      int_req_r |-> ($past(pend) & (11'h001 << win_idx_r)) != 11'h000)
      else $error("request raised without enabled pending source");

   chk_vec_ext0: assert property ( // RULE6
      (int_req_r && win_idx_r == SRC_EXT0) |-> vec_r == 16'h0003)
      else $error("external zero vector wrong");

   chk_poll_tie: assert property ( // RULE3
      (pend[SRC_EXT0] && pend[SRC_SER1]) |=> win_idx_r != SRC_SER1)
      else $error("serial one beat external zero at same level");

   chk_preempt_level: assert property ( // RULE11
      (int_req_r && is_r != 4'h0) |-> win_lvl_r > cur_lvl)
      else $error("request did not outrank running handler");

   chk_ext0_edge: assert property ( // RULE9
      (type_r[TYPE_EXT0] && ext0_prev_r && !ext0_n) |=> flag_r[SRC_EXT0])
      else $error("falling edge on external zero missed");

   chk_wake_path: assert property ( // RULE7
      (cpu_stopped && en_r[SRC_EXT0] && !ext0_n) |-> wake_req)
      else $error("wake not raised");

   chk_periph_clear: assert property ( // RULE10
      (rd_per && per_in == '0) |=> periph_r == '0)
      else $error("peripheral flags not cleared by read");

   chk_serial_req: assert property ( // RULE12
      (ser0_rx || ser0_tx) |=> flag_r[SRC_SER0])
      else $error("serial zero flag not set");

   chk_wdt_inert: assert property ( // RULE8
      (int_req_r && win_idx_r == SRC_EXT6)
      |-> win_lvl_r == $past({prio_hi_r[5], prio_lo_r[5]}))
      else $error("level not from bit five of priority registers");

   chk_vec_ser1: assert property ( // RULE6
      (int_req_r && win_idx_r == SRC_SER1) |-> vec_r == 16'h0083)
      else $error("serial one vector wrong");

   chk_group_pair: assert property ( // RULE1
      (int_req_r && win_idx_r == SRC_EXT4)
      |-> win_lvl_r == $past({prio_hi_r[3], prio_lo_r[3]}))
      else $error("external four not ranked with group three");

   chk_equal_waits: assert property ( // RULE11
      (is_r != 4'h0 && win_lvl <= cur_lvl) |=> !int_req_r)
      else $error("request raised at or below running level");

   chk_ext0_level: assert property ( // RULE9
      (!type_r[TYPE_EXT0] && !ext0_n) |=> flag_r[SRC_EXT0])
      else $error("low level on external zero missed");

   chk_ext4_rise: assert property ( // RULE10
      (por[0] && !por_prev_r[0]) |=> flag_r[SRC_EXT4])
      else $error("rising edge on external four missed");

   chk_ack_drops_req: assert property ( // RULE5
      (int_ack && int_req_r) |=> !int_req_r)
      else $error("request stayed up after accept");

   chk_disabled_quiet: assert property ( // RULE4
      (en_r == 11'h000) |=> !int_req_r)
      else $error("request raised with every source disabled");

endmodule : ivp_ctrl

/* File: bench/ivp_cpu_model.sv */
// cpu side model: accepts requests and returns from handlers
// assumes the ivp_ctrl request handshake, all on hclk
`timescale 1ns/1ns
module ivp_cpu_model (
   input  wire logic       hclk,     // clock
   input  wire logic       hresetn,  // reset, active low
   input  wire logic       int_req,  // request from block
   input  wire logic       go,       // accepting allowed
   input  wire logic       auto_ret, // return by itself
   input  wire logic       ret_cmd,  // return now
   input  wire logic [2:0] dly,      // cycles before accepting
   output logic            int_ack,  // accept pulse
   output logic            int_ret   // return pulse
);
   // ==========
   // accept and return
   logic [2:0] rc_r;
   logic [2:0] wc_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_ack <= 1'b0;
         int_ret <= 1'b0;
         rc_r    <= 3'h0;
         wc_r    <= 3'h0;
      end else begin
         int_ack <= 1'b0;
         int_ret <= ret_cmd || (rc_r == 3'h1);
         wc_r    <= 3'h0;
         // request still stands in the cycle after an accept, so skip it
         if (go && int_req && !int_ack) begin
            wc_r    <= wc_r + 3'h1;
            int_ack <= (wc_r == dly);
         end
         if (int_ack && auto_ret) begin
            rc_r <= 3'h4;
         end else if (rc_r != 3'h0) begin
            rc_r <= rc_r - 3'h1;
         end
      end
   end
endmodule : ivp_cpu_model

/* File: bench/tb.sv */
// testbench for ivp_ctrl: register access, requests, vectors, priority
// assumes ivp_pkg and the cpu model in ivp_cpu_model.sv
`timescale 1ns/1ns
module tb;
   import ivp_pkg::*;
   // ==========
   // signals
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, d;
   logic [1:0]  htrans = 2'h0, int_level;
   logic [2:0]  hsize = 3'h2, dly = 3'h0;
   logic        ext0_n = 1'b1, ext1_n = 1'b1, ext2_pin = 1'b0, ext3_pin = 1'b0;
   logic [3:0]  ext4_src = '0, ext5_src = '0, ext6_src = '0;
   logic        tmr0_ovf = 1'b0, tmr1_ovf = 1'b0, ser0_rx = 1'b0, ser0_tx = 1'b0;
   logic        ser1_rx = 1'b0, ser1_tx = 1'b0, cpu_stopped = 1'b0;
   logic        int_ack, int_ret, int_req, wake_req, irq, hreadyout, hresp;
   logic        go = 1'b0, auto_ret = 1'b1, ret_cmd = 1'b0;
   logic [15:0] int_vector;
   int          mismatches = 0, comparisons = 0, cyc = 0;
   localparam logic [15:0] VEC [11] = '{16'h0003, 16'h0083, 16'h000b, 16'h004b, 16'h0013,
      16'h0053, 16'h001b, 16'h0023, 16'h005b, 16'h0063, 16'h006b};
   localparam int ORD [11] = '{10, 6, 8, 4, 5, 0, 1, 2, 3, 7, 9};
   localparam logic [1:0] LV [11] = '{3, 2, 2, 1, 1, 0, 0, 0, 0, 0, 0};
   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   ivp_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hrdata, .hreadyout, .hresp, .ext0_n, .ext1_n, .ext2_pin, .ext3_pin,
      .ext4_src, .ext5_src, .ext6_src, .tmr0_ovf, .tmr1_ovf, .ser0_rx, .ser0_tx,
      .ser1_rx, .ser1_tx, .cpu_stopped, .int_ack, .int_ret, .int_req, .int_vector,
      .int_level, .wake_req, .irq);
   ivp_cpu_model cpu (.hclk, .hresetn, .int_req, .go, .auto_ret, .ret_cmd, .dly,
      .int_ack, .int_ret);
   // ==========
   // helpers
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 6000) begin
         mismatches++;
         wrap_up();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // hready is sampled at the negedge; nothing changes it before the next rise
   task automatic bus(input logic w, input logic [9:0] ix, input logic [31:0] wd);
      logic r;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0, ix, 2'h0};
      hwrite <= w;
      do begin
         @(negedge hclk);
         r = hreadyout;
         @(posedge hclk);
      end while (r !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(negedge hclk);
         r = hreadyout;
         d = hrdata;
         @(posedge hclk);
      end while (r !== 1'b1);
   endtask : bus
   task automatic wr(input logic [9:0] ix, input logic [31:0] wd);
      bus(1'b1, ix, wd);
   endtask : wr
   task automatic rdc(input logic [9:0] ix, input logic [31:0] e, input string nm);
      bus(1'b0, ix, 32'h0);
      chk(nm, e, d);
   endtask : rdc
   task automatic drive(input logic [10:0] m, input logic a);
      ext0_n <= ~m[0];
      ser1_rx <= m[1] & ~a;
      ser1_tx <= m[1] & a;
      tmr0_ovf <= m[2];
      ext2_pin <= m[3];
      ext1_n <= ~m[4];
      ext3_pin <= m[5];
      tmr1_ovf <= m[6];
      ser0_tx <= m[7] & ~a;
      ser0_rx <= m[7] & a;
      ext4_src <= {3'h0, m[8]};
      ext5_src <= {3'h0, m[9]};
      ext6_src <= {3'h0, m[10]};
   endtask : drive
   task automatic fire(input logic [10:0] m, input logic a);
      drive(m, a);
      @(posedge hclk);
      drive(11'h000, 1'b0);
      @(posedge hclk);
   endtask : fire
   task automatic take(input logic [15:0] ev, input logic [1:0] el);
      int n;
      n = 0;
      do begin
         @(negedge hclk);
         n++;
      end while (int_ack !== 1'b1 && n < 300);
      chk("vector", {16'h0, ev}, {16'h0, int_vector});
      chk("level", {30'h0, el}, {30'h0, int_level});
      @(posedge hclk);
   endtask : take
   task automatic ret();
      ret_cmd <= 1'b1;
      @(posedge hclk);
      ret_cmd <= 1'b0;
      repeat (6) @(posedge hclk);
   endtask : ret
   // ==========
   // scenarios
   task automatic t_regs();
      rdc(IDX_PRIO_LO, 32'h0, "prio_lo");
      rdc(IDX_PRIO_HI, 32'h0, "prio_hi");
      wr(IDX_PRIO_LO, 32'hff);
      rdc(IDX_PRIO_LO, 32'h7f, "prio_lo");
      wr(IDX_PRIO_HI, 32'hff);
      rdc(IDX_PRIO_HI, 32'h3f, "prio_hi");
      wr(10'h3ff, 32'hffffffff);
      rdc(10'h3ff, 32'h0, "unmapped");
      rdc(IDX_ENABLE, 32'h0, "enable");
      chk("hresp", 32'h0, hresp);
      wr(IDX_PRIO_LO, 32'h0);
      wr(IDX_PRIO_HI, 32'h0);
   endtask : t_regs
   task automatic t_mask();
      wr(IDX_TYPE, 32'hf);
      rdc(IDX_TYPE, 32'hf, "type");
      wr(IDX_MASK, 32'h4);
      go <= 1'b1;
      fire(11'h004, 1'b0);
      repeat (8) @(posedge hclk);
      chk("req disabled", 32'h0, int_req);
      rdc(IDX_FLAGS, 32'h4, "flags");
      chk("irq", 32'h1, irq);
      rdc(IDX_STAT, 32'h4, "status");
      wr(IDX_MASK, 32'h0);
      rdc(IDX_MASK, 32'h0, "mask");
      chk("irq", 32'h0, irq);
      wr(IDX_MASK, 32'h4);
      wr(IDX_STAT, 32'h4);
      rdc(IDX_STAT, 32'h0, "status");
      chk("irq", 32'h0, irq);
      wr(IDX_ENABLE, 32'h7ff);
      take(16'h000b, 2'h0);
      rdc(IDX_FLAGS, 32'h0, "flags");
   endtask : t_mask
   task automatic t_order(input logic b);
      go <= 1'b0;
      wr(IDX_PRIO_LO, b ? 32'h24 : 32'h40);
      wr(IDX_PRIO_HI, b ? 32'h28 : 32'h00);
      fire(11'h7ff, 1'b0);
      go <= 1'b1;
      for (int k = 0; k < 11; k++) begin
         take(VEC[b ? ORD[k] : k], b ? LV[k] : 2'h0);
      end
      rdc(IDX_PERIPH, 32'h111, "periph");
   endtask : t_order
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_mask();
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 11; i++) begin
            dly <= 3'(i % 3);
            fire(11'h1 << i, p[0]);
            take(VEC[i], 2'h0);
            if (i >= 8) begin
               rdc(IDX_PERIPH, 32'h1 << (4 * (i - 8)), "periph");
            end
         end
      end
      t_order(1'b0);
      t_order(1'b1);
      // preemption: group five at level three, all others at level zero
      auto_ret <= 1'b0;
      wr(IDX_PRIO_LO, 32'h20);
      wr(IDX_PRIO_HI, 32'h20);
      fire(11'h004, 1'b0);
      take(16'h000b, 2'h0);
      fire(11'h040, 1'b0);
      repeat (10) @(posedge hclk);
      chk("req equal", 32'h0, int_req);
      fire(11'h400, 1'b0);
      take(16'h006b, 2'h3);
      ret();
      chk("req lower", 32'h0, int_req);
      go <= 1'b0;
      ret();
      go <= 1'b1;
      take(16'h001b, 2'h0);
      ret();
      auto_ret <= 1'b1;
      // external zero held low: edge mode once, level mode repeatedly
      drive(11'h001, 1'b0);
      take(16'h0003, 2'h0);
      repeat (12) @(posedge hclk);
      chk("req edge", 32'h0, int_req);
      wr(IDX_TYPE, 32'he);
      take(16'h0003, 2'h0);
      take(16'h0003, 2'h0);
      drive(11'h000, 1'b0);
      take(16'h0003, 2'h0);
      repeat (12) @(posedge hclk);
      chk("req level", 32'h0, int_req);
      wr(IDX_TYPE, 32'hf);
      go <= 1'b0;
      cpu_stopped <= 1'b1;
      drive(11'h001, 1'b0);
      @(negedge hclk);
      chk("wake", 32'h1, wake_req);
      @(posedge hclk);
      drive(11'h000, 1'b0);
      @(negedge hclk);
      chk("wake", 32'h0, wake_req);
      @(posedge hclk);
      cpu_stopped <= 1'b0;
      go <= 1'b1;
      take(16'h0003, 2'h0);
      ext5_src <= 4'h4;
      take(16'h0063, 2'h0);
      repeat (12) @(posedge hclk);
      chk("req held", 32'h0, int_req);
      ext5_src <= 4'h0;
      rdc(IDX_PERIPH, 32'h140, "periph");
      rdc(IDX_PERIPH, 32'h0, "periph");
      wrap_up();
   end
endmodule : tb
